// >>> design/fis_pkg.sv
// constants and types shared by the flash program sequencer
package fis_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CMD_STAT_ADDR = 8'hd5;
  localparam logic [7:0] DATA_PORT_ADDR = 8'hd6;
  localparam int BUSY_BIT = 7;
  localparam int ERR_BIT = 6;
  localparam int BANK_BIT = 4;
  localparam logic [3:0] CMD_RESET_VAL = 4'h0;
  localparam logic BUSY_N_RESET_VAL = 1'b1;
  localparam logic [7:0] DATA_RESET_VAL = 8'h00;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [3:0] CMD_READ_MODE = 4'h0;
  localparam logic [3:0] CMD_VFY_OPT = 4'h1;
  localparam logic [3:0] CMD_VFY_SEC = 4'h2;
  localparam logic [3:0] CMD_VFY_UPPER = 4'h3;
  localparam logic [3:0] CMD_VFY_BANK = 4'h4;
  localparam logic [3:0] CMD_FLIP_BANK = 4'h8;
  localparam logic [3:0] CMD_WR_OPT = 4'h9;
  localparam logic [3:0] CMD_WR_SEC = 4'ha;
  localparam logic [3:0] CMD_WR_UPPER = 4'hb;
  localparam logic [3:0] CMD_ER_OPT = 4'hc;
  localparam logic [3:0] CMD_ER_SEC = 4'hd;
  localparam logic [3:0] CMD_ER_UPPER = 4'he;
  localparam logic [3:0] CMD_SYS_RESET = 4'hf;

  // upper bank spans 2000h..3fffh: high address byte 001x_xxxx
  localparam logic [2:0] UPPER_HI_TAG = 3'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 100000;
  localparam int PROG_CYC = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_TIME_US = 828000;
  localparam int ERASE_CYC = ERASE_TIME_US / CLK_PERIOD_NS * 1000;
  localparam int TMR_W = 25;

  typedef enum logic [1:0] {
    FIS_IDLE,
    FIS_VERIFY,
    FIS_RUN
  } fis_state_t;
endpackage

// >>> design/fis_seq_if.sv
// link between the sequencer, its operation timer and its bank map
`timescale 1ns/10ps
interface fis_seq_if;
  logic tmr_start;
  logic tmr_long;
  logic tmr_done;
  logic [12:0] map_off;
  logic [13:0] phys_addr;
  modport seq (output tmr_start, output tmr_long, output map_off, input tmr_done, input phys_addr);
  modport tmr (input tmr_start, input tmr_long, output tmr_done);
  modport map (input map_off, output phys_addr);
endinterface

// >>> design/fis_op_timer.sv
// self-timing counter for program and erase operations
`timescale 1ns/10ps
module fis_op_timer #(
  parameter int unsigned PROG_CYCLES = fis_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYCLES = fis_pkg::ERASE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  fis_seq_if.tmr seq
);
  logic [fis_pkg::TMR_W-1:0] count;
  logic running;

  // counts must fit the counter and be at least one cycle
  if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << fis_pkg::TMR_W) ||
      PROG_CYCLES >= (1 << fis_pkg::TMR_W)) begin : g_bad
    $error("operation cycle counts out of range");
  end

  // load on start, run down to zero, done on the last cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count <= '0;
      running <= 1'b0;
    end else if (seq.tmr_start) begin
      running <= 1'b1;
      count <= seq.tmr_long ? fis_pkg::TMR_W'(ERASE_CYCLES - 1) : fis_pkg::TMR_W'(PROG_CYCLES - 1);
    end else if (running) begin
      if (count == '0) begin
        running <= 1'b0;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  assign seq.tmr_done = running && (count == '0);
endmodule

// >>> design/fis_bank_map.sv
// bank map: which physical bank sits low, caught once after each reset
`timescale 1ns/10ps
module fis_bank_map (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bank_cell,
  output logic lower_bank_sel,
  fis_seq_if.map seq
);
  logic bank_lat;
  logic caught;

  // the cell is sampled after release, so a flip shows only after a reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bank_lat <= 1'b0;
      caught <= 1'b0;
    end else if (!caught) begin
      bank_lat <= bank_cell; // R4
      caught <= 1'b1;
    end
  end

  assign lower_bank_sel = bank_lat;
  // upper bank is always the physical bank not mapped low
  assign seq.phys_addr = {~bank_lat, seq.map_off}; // R4
endmodule

// >>> design/fis_flash_seq.sv
// in-application flash sequencer: command/status and address/data port
// ****************************************
// How it works
// R1: command write enables flash and data port
// R2: address/data bytes in, verify result out
// R3: erase and program reach upper bank only
// R4: bank cell picks lower bank at reset
// R5: busy_n low from start until end or fail
// R6: operation starts on its last data byte
// R7: failure aborts, sets error; flags read-only
// R8: lock bits never gate this path
// R9: command field bits 3:0, zero is read mode
// R10: 0001 reads option byte next cycle
// R11: 0010 reads security byte at given address
// R12: 0011 reads upper byte from two addresses
// R13: 0100 returns bank cell in bit 4
// R14: 1000 flips bank cell, 1111 resets system
// R15: 1001 programs option byte from data
// R16: 1010 programs security byte: address, data
// R17: 1011 programs upper byte: hi, lo, data
// R18: 1100 erases option byte to ffh
// R19: 1101 erases whole security block to ffh
// R20: 1110 erases whole upper bank to ffh
// R21: reset clears command; software writes zero
// R22: timed access only; ignored while busy
// ****************************************
`timescale 1ns/10ps
module fis_flash_seq #(
  parameter int unsigned ERASE_CYCLES = fis_pkg::ERASE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic timed_access_ok,
  output logic arr_strobe,
  output logic [3:0] arr_op,
  output logic [13:0] arr_addr,
  output logic [7:0] arr_wdata,
  input wire logic [7:0] arr_rdata,
  input wire logic arr_fail,
  output logic arr_abort,
  input wire logic bank_cell,
  output logic lower_bank_sel,
  output logic sys_reset_req
);
  // ****************************************
  // functions
  // ****************************************
  // data bytes each command collects before it starts
  function automatic logic [1:0] need_bytes(input logic [3:0] cmd);
    unique case (cmd)
      fis_pkg::CMD_VFY_SEC, fis_pkg::CMD_WR_OPT: need_bytes = 2'd1;
      fis_pkg::CMD_VFY_UPPER, fis_pkg::CMD_WR_SEC: need_bytes = 2'd2;
      fis_pkg::CMD_WR_UPPER: need_bytes = 2'd3;
      default: need_bytes = 2'd0;
    endcase
  endfunction

  function automatic logic is_verify(input logic [3:0] cmd);
    is_verify = (cmd == fis_pkg::CMD_VFY_OPT) || (cmd == fis_pkg::CMD_VFY_SEC) ||
                (cmd == fis_pkg::CMD_VFY_UPPER) || (cmd == fis_pkg::CMD_VFY_BANK);
  endfunction

  // R18 R19 R20
  function automatic logic is_erase(input logic [3:0] cmd);
    is_erase = (cmd == fis_pkg::CMD_ER_OPT) || (cmd == fis_pkg::CMD_ER_SEC) ||
               (cmd == fis_pkg::CMD_ER_UPPER);
  endfunction

  function automatic logic is_write(input logic [3:0] cmd);
    is_write = (cmd == fis_pkg::CMD_WR_OPT) || (cmd == fis_pkg::CMD_WR_SEC) ||
               (cmd == fis_pkg::CMD_WR_UPPER) || (cmd == fis_pkg::CMD_FLIP_BANK);
  endfunction

  // ****************************************
  // state
  // ****************************************
  fis_seq_if link ();
  fis_pkg::fis_state_t state;
  logic [3:0] command_code;
  logic op_busy_n;
  logic op_error_flag;
  logic [7:0] data_reg;
  logic [7:0] addr_hi;
  logic [7:0] addr_lo;
  logic [1:0] bytes_seen;
  logic cmd_wr;
  logic cmd_take;
  logic data_wr;
  logic last_byte;
  logic [3:0] eff_cmd;
  logic range_bad;
  logic go_verify;
  logic go_run;
  logic [12:0] next_off;

  fis_op_timer #(
    .PROG_CYCLES(fis_pkg::PROG_CYC),
    .ERASE_CYCLES(ERASE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .seq(link.tmr)
  );

  fis_bank_map u_map (
    .core_clk(core_clk),
    .reset(reset),
    .bank_cell(bank_cell),
    .lower_bank_sel(lower_bank_sel),
    .seq(link.map)
  );

  // ****************************************
  // register access decode
  // ****************************************
  // command writes need the unlock window and an idle sequencer
  assign cmd_wr = sfr_wr && (sfr_addr == fis_pkg::CMD_STAT_ADDR);
  assign cmd_take = cmd_wr && timed_access_ok && op_busy_n && (state == fis_pkg::FIS_IDLE); // R22
  assign eff_cmd = cmd_take ? sfr_wdata[3:0] : command_code;
  // data port only live under a non-zero command; bytes past a full set start a new set
  assign data_wr = sfr_wr && (sfr_addr == fis_pkg::DATA_PORT_ADDR) && (command_code != fis_pkg::CMD_READ_MODE) &&
                   (state == fis_pkg::FIS_IDLE) && (bytes_seen < need_bytes(command_code)); // R1
  assign last_byte = data_wr && ((bytes_seen + 2'd1) == need_bytes(command_code)); // R6
  // the first address byte of a bank write must sit in 20h..3fh
  assign range_bad = (command_code == fis_pkg::CMD_WR_UPPER) && (addr_hi[7:5] != fis_pkg::UPPER_HI_TAG); // R3
  // lock bits are deliberately not consulted anywhere here
  assign go_verify = is_verify(eff_cmd) && (cmd_take ? (need_bytes(eff_cmd) == 2'd0) : last_byte); // R8
  // the range check belongs to the bank write only, so a stale bad address never blocks a fresh command
  assign go_run = cmd_take ? (is_erase(eff_cmd) || eff_cmd == fis_pkg::CMD_FLIP_BANK)
                           : (last_byte && is_write(command_code) && !range_bad); // R6 R3
  // offset inside the upper bank, low address taken from this write when it is the second byte
  assign next_off = (command_code == fis_pkg::CMD_VFY_UPPER && last_byte) ? {addr_hi[4:0], sfr_wdata}
                                                                           : {addr_hi[4:0], addr_lo};
  assign link.map_off = next_off; // R3
  assign link.tmr_start = go_run;
  assign link.tmr_long = is_erase(eff_cmd);

  // ****************************************
  // command field
  // ****************************************
  // cleared by every reset; only software brings it back to read mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      command_code <= fis_pkg::CMD_RESET_VAL; // R21
    end else if (cmd_take) begin
      command_code <= sfr_wdata[3:0]; // R9
    end
  end

  // ****************************************
  // address bytes and byte count
  // ****************************************
  // a new command restarts collection; a full set rearms it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bytes_seen <= 2'd0;
      addr_hi <= 8'h00;
      addr_lo <= 8'h00;
    end else if (cmd_take || last_byte) begin
      bytes_seen <= 2'd0;
      if (last_byte && bytes_seen == 2'd1) begin
        addr_lo <= sfr_wdata;
      end
    end else if (data_wr) begin
      bytes_seen <= bytes_seen + 2'd1;
      if (bytes_seen == 2'd0) begin
        addr_hi <= sfr_wdata; // R2
      end else begin
        addr_lo <= sfr_wdata;
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // one verify cycle, or a timed run that a failure cuts short
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= fis_pkg::FIS_IDLE;
      op_busy_n <= fis_pkg::BUSY_N_RESET_VAL;
      arr_abort <= 1'b0;
    end else begin
      arr_abort <= 1'b0;
      unique case (state)
        fis_pkg::FIS_IDLE: begin
          if (go_run) begin
            state <= fis_pkg::FIS_RUN;
            op_busy_n <= 1'b0; // R5
          end else if (go_verify) begin
            state <= fis_pkg::FIS_VERIFY;
          end
        end
        fis_pkg::FIS_VERIFY: begin
          state <= fis_pkg::FIS_IDLE;
        end
        fis_pkg::FIS_RUN: begin
          if (arr_fail) begin
            state <= fis_pkg::FIS_IDLE;
            op_busy_n <= 1'b1; // R7
            arr_abort <= 1'b1;
          end else if (link.tmr_done) begin
            state <= fis_pkg::FIS_IDLE;
            op_busy_n <= 1'b1; // R5
          end
        end
      endcase
    end
  end

  // ****************************************
  // error flag
  // ****************************************
  // set wins over the clear that a fresh command brings
  always_ff @(posedge core_clk) begin
    if (reset) begin
      op_error_flag <= 1'b0;
    end else if ((state == fis_pkg::FIS_RUN && arr_fail) || (last_byte && range_bad)) begin
      op_error_flag <= 1'b1; // R7
    end else if (cmd_take) begin
      op_error_flag <= 1'b0;
    end
  end

  // ****************************************
  // array request
  // ****************************************
  // strobe is one cycle; the array reads combinationally under it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      arr_strobe <= 1'b0;
      arr_op <= fis_pkg::CMD_READ_MODE;
      arr_addr <= 14'h0000;
      arr_wdata <= 8'h00;
    end else begin
      arr_strobe <= (go_run || go_verify) && eff_cmd != fis_pkg::CMD_VFY_BANK; // R6
      if (go_run || go_verify) begin
        arr_op <= eff_cmd; // R14
        unique case (eff_cmd)
          fis_pkg::CMD_VFY_UPPER, fis_pkg::CMD_WR_UPPER, fis_pkg::CMD_ER_UPPER:
            arr_addr <= link.phys_addr; // R12
          fis_pkg::CMD_VFY_SEC: arr_addr <= {6'h00, sfr_wdata}; // R11
          fis_pkg::CMD_WR_SEC: arr_addr <= {6'h00, addr_hi}; // R16
          default: arr_addr <= 14'h0000;
        endcase
        arr_wdata <= sfr_wdata; // R15 R17
      end
    end
  end

  // system reset request pulses once per accepted 1111 (system reset) command
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= cmd_take && (sfr_wdata[3:0] == fis_pkg::CMD_SYS_RESET); // R14
    end
  end

  // ****************************************
  // data register
  // ****************************************
  // verify data lands at the end of the cycle after the request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_reg <= fis_pkg::DATA_RESET_VAL;
    end else if (state == fis_pkg::FIS_VERIFY) begin
      if (command_code == fis_pkg::CMD_VFY_BANK) begin
        data_reg <= 8'h00;
        data_reg[fis_pkg::BANK_BIT] <= bank_cell; // R13
      end else begin
        data_reg <= arr_rdata; // R2 R10 R11 R12
      end
    end else if (data_wr) begin
      data_reg <= sfr_wdata;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // flags are read-only; bits 5:4 read as zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd && sfr_addr == fis_pkg::CMD_STAT_ADDR) begin
      sfr_rdata <= {op_busy_n, op_error_flag, 2'b00, command_code}; // R7
    end else if (sfr_rd && sfr_addr == fis_pkg::DATA_PORT_ADDR) begin
      sfr_rdata <= (command_code != fis_pkg::CMD_READ_MODE) ? data_reg : 8'h00; // R1
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  busy_start_a: assert property (@(posedge core_clk) disable iff (reset) go_run |=> !op_busy_n) // R5
    else $error("busy_n not low after start");
  busy_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (state == fis_pkg::FIS_RUN && !arr_fail && !link.tmr_done) |=> !op_busy_n) // R5
    else $error("busy_n rose during operation");
  fail_error_a: assert property (@(posedge core_clk) disable iff (reset)
    (state == fis_pkg::FIS_RUN && arr_fail) |=> op_error_flag && op_busy_n && arr_abort) // R7
    else $error("failure not reported");
  cmd_ignore_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_wr && (!op_busy_n || !timed_access_ok)) |=> $stable(command_code)) // R22
    else $error("command taken while locked or busy");
  reset_clear_a: assert property (@(posedge core_clk) reset |=> command_code == 4'h0 && op_busy_n) // R21
    else $error("reset did not clear command");
  upper_verify_a: assert property (@(posedge core_clk) disable iff (reset)
    (last_byte && command_code == fis_pkg::CMD_VFY_UPPER) |=> arr_strobe ##1 data_reg == $past(arr_rdata)) // R12
    else $error("upper verify data late");
  auto_start_a: assert property (@(posedge core_clk) disable iff (reset)
    (last_byte && command_code == fis_pkg::CMD_WR_UPPER && !range_bad) |=> arr_strobe && arr_addr[13] != lower_bank_sel) // R3
    else $error("bank write not started in upper bank");
  bank_verify_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_take && sfr_wdata[3:0] == fis_pkg::CMD_VFY_BANK) |=> ##1 data_reg[4] == $past(bank_cell)) // R13
    else $error("bank verify value wrong");
  data_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    (sfr_wr && sfr_addr == fis_pkg::DATA_PORT_ADDR && command_code == 4'h0) |=> $stable(data_reg)) // R1
    else $error("data port written in read mode");
  // pulses and refusals that the bench only sees indirectly
  range_error_a: assert property (@(posedge core_clk) disable iff (reset)
    (last_byte && range_bad) |=> op_error_flag && !arr_strobe) // R3
    else $error("lower bank write not refused");
  sys_reset_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_take && sfr_wdata[3:0] == fis_pkg::CMD_SYS_RESET) |=> sys_reset_req) // R14
    else $error("system reset not requested");
  strobe_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    arr_strobe |=> !arr_strobe) // R6
    else $error("array strobe longer than one cycle");
  verify_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    go_verify |=> op_busy_n) // R5
    else $error("verify cleared busy_n");
  abort_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
    arr_abort |=> !arr_abort) // R7
    else $error("abort longer than one cycle");
  read_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    (sfr_rd && sfr_addr == fis_pkg::DATA_PORT_ADDR && command_code == fis_pkg::CMD_READ_MODE) |=>
    sfr_rdata == 8'h00) // R1
    else $error("data port readable in read mode");
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the flash program sequencer, driven over its register port
`timescale 1ns/10ps
module tb_top;
  localparam int ERASE_N = 20;
  localparam logic [7:0] CA = fis_pkg::CMD_STAT_ADDR;
  localparam logic [7:0] DA = fis_pkg::DATA_PORT_ADDR;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic timed_access_ok = 1'b0;
  logic arr_strobe;
  logic [3:0] arr_op;
  logic [13:0] arr_addr;
  logic [7:0] arr_wdata;
  logic [7:0] arr_rdata = 8'h00;
  logic arr_fail = 1'b0;
  logic arr_abort;
  logic bank_cell = 1'b1;
  logic lower_bank_sel;
  logic sys_reset_req;
  int miscompares = 0;
  int check_count = 0;
  int strobes = 0;
  int aborts = 0;
  int sys_reqs = 0;
  int n0;
  logic [3:0] last_op = 4'h0;
  logic [13:0] last_addr = 14'h0000;
  logic [7:0] last_wdata = 8'h00;
  logic [7:0] v;
  logic [3:0] c;
  logic [3:0] ops [7] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h8};

  fis_flash_seq #(.ERASE_CYCLES(ERASE_N)) dut_u (
    .core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timed_access_ok(timed_access_ok),
    .arr_strobe(arr_strobe), .arr_op(arr_op), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_rdata(arr_rdata), .arr_fail(arr_fail), .arr_abort(arr_abort), .bank_cell(bank_cell),
    .lower_bank_sel(lower_bank_sel), .sys_reset_req(sys_reset_req)
  );

  // 20 mhz clock
  always #25 core_clk = ~core_clk;

  // ****************************************
  // array stand-in: logs requests, flips the cell
  // ****************************************
  always @(posedge core_clk) begin
    if (arr_strobe === 1'b1) begin
      strobes <= strobes + 1;
      last_op <= arr_op;
      last_addr <= arr_addr;
      last_wdata <= arr_wdata;
      if (arr_op === fis_pkg::CMD_FLIP_BANK) bank_cell <= ~bank_cell;
    end
    if (arr_abort === 1'b1) aborts <= aborts + 1;
    if (sys_reset_req === 1'b1) sys_reqs <= sys_reqs + 1;
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    timed_access_ok <= ta;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    timed_access_ok <= 1'b0;
  endtask

  // read data is registered, so it is taken a step after the sampling edge
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 v = sfr_rdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(what, {8'h00, v}, {8'h00, exp});
  endtask

  function automatic logic [7:0] stat(input logic b, input logic e, input logic [3:0] cc);
    return {b, e, 2'b00, cc};
  endfunction

  // bounded poll: a hung busy shows as one miscompare
  task automatic wait_idle();
    int n;
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 1500) begin
      rd(CA);
      n++;
    end
    check("busy release", {15'h0000, v[7]}, 16'h0001);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // watchdog: program ops dominate the run time
  // ****************************************
  initial begin
    #(20000 * 50);
    miscompares++;
    complete_run();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    do_reset();
    check("bank low", {15'h0000, lower_bank_sel}, 16'h0001);
    rd_chk("status reset", CA, 8'h80);
    rd_chk("data idle", DA, 8'h00);
    rd_chk("unmapped", 8'hd7, 8'h00);
    wr(CA, 8'h03, 1'b0);
    rd_chk("no unlock", CA, 8'h80);
    wr(CA, 8'h40, 1'b1);
    rd_chk("flags read only", CA, 8'h80);
    arr_rdata <= 8'ha5;
    wr(CA, 8'h01, 1'b1);
    repeat (2) @(posedge core_clk);
    rd_chk("option verify", DA, 8'ha5);
    rd_chk("busy kept", CA, 8'h81);
    // every lock bit shown programmed, yet the path stays open
    arr_rdata <= 8'hc7;
    wr(CA, 8'h02, 1'b1);
    wr(DA, 8'h40, 1'b0);
    repeat (2) @(posedge core_clk);
    rd_chk("security verify", DA, 8'hc7);
    check("security addr", {8'h00, last_addr[7:0]}, 16'h0040);
    arr_rdata <= 8'h3c;
    wr(CA, 8'h03, 1'b1);
    wr(DA, 8'h20, 1'b0);
    wr(DA, 8'h10, 1'b0);
    repeat (2) @(posedge core_clk);
    rd_chk("upper verify", DA, 8'h3c);
    check("upper addr", {2'b00, last_addr}, {2'b00, ~lower_bank_sel, 13'h0010});
    wr(CA, 8'h04, 1'b1);
    repeat (2) @(posedge core_clk);
    rd(DA);
    check("bank verify", {15'h0000, v[fis_pkg::BANK_BIT]}, {15'h0000, bank_cell});
    // timed operations, each with a command refused mid-run
    foreach (ops[k]) begin
      c = ops[k];
      n0 = strobes;
      wr(CA, {4'h0, c}, 1'b1);
      case (c)
        fis_pkg::CMD_WR_OPT: wr(DA, 8'hf7, 1'b0);
        fis_pkg::CMD_WR_SEC: begin
          wr(DA, 8'h40, 1'b0);
          wr(DA, 8'h28, 1'b0);
        end
        fis_pkg::CMD_WR_UPPER: begin
          wr(DA, 8'h21, 1'b0);
          wr(DA, 8'h34, 1'b0);
          wr(DA, 8'h5a, 1'b0);
        end
        default: ;
      endcase
      rd_chk("status busy", CA, stat(1'b0, 1'b0, c));
      wr(CA, 8'h00, 1'b1);
      rd_chk("cmd while busy", CA, stat(1'b0, 1'b0, c));
      check("one strobe", 16'(strobes - n0), 16'h0001);
      check("array op", {12'h000, last_op}, {12'h000, c});
      case (c)
        fis_pkg::CMD_WR_OPT: check("option data", {8'h00, last_wdata}, 16'h00f7);
        fis_pkg::CMD_WR_SEC: check("sec addr data", {last_addr[7:0], last_wdata}, 16'h4028);
        fis_pkg::CMD_WR_UPPER: begin
          check("prog addr", {2'b00, last_addr}, {2'b00, ~lower_bank_sel, 13'h0134});
          check("prog data", {8'h00, last_wdata}, 16'h005a);
        end
        default: ;
      endcase
      wait_idle();
      rd_chk("status done", CA, stat(1'b1, 1'b0, c));
      wr(CA, 8'h00, 1'b1);
      rd_chk("read mode", CA, 8'h80);
    end
    // lower-bank address refused with an error, no array request
    n0 = strobes;
    wr(CA, 8'h0b, 1'b1);
    wr(DA, 8'h1f, 1'b0);
    wr(DA, 8'h00, 1'b0);
    wr(DA, 8'h66, 1'b0);
    rd_chk("lower bank refused", CA, 8'hcb);
    check("no strobe", 16'(strobes - n0), 16'h0000);
    wr(CA, 8'h00, 1'b1);
    // array failure during an erase
    arr_fail <= 1'b1;
    wr(CA, 8'h0e, 1'b1);
    wait_idle();
    arr_fail <= 1'b0;
    rd_chk("fail status", CA, 8'hce);
    check("abort pulse", 16'(aborts), 16'h0001);
    wr(CA, 8'h00, 1'b1);
    rd_chk("error cleared", CA, 8'h80);
    // system reset swaps the bank after the flip
    wr(CA, 8'h0f, 1'b1);
    repeat (2) @(posedge core_clk);
    check("reset request", 16'(sys_reqs), 16'h0001);
    do_reset();
    check("bank swapped", {15'h0000, lower_bank_sel}, 16'h0000);
    rd_chk("cmd cleared", CA, 8'h80);
    wr(CA, 8'h03, 1'b1);
    wr(DA, 8'h3f, 1'b0);
    wr(DA, 8'hff, 1'b0);
    repeat (2) @(posedge core_clk);
    check("upper after swap", {2'b00, last_addr}, 16'h3fff);
    // data port write under read mode must leave the held byte alone
    wr(CA, 8'h00, 1'b1);
    wr(DA, 8'h5a, 1'b0);
    wr(CA, 8'h02, 1'b1);
    rd_chk("data port locked", DA, 8'h3c);
    complete_run();
  end
endmodule
